// ===== pkg/pws_pkg.sv
package pws_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  localparam int         ADDR_W         = 8;
  localparam int         DATA_W         = 16;
  localparam logic [7:0] ADR_CTRL       = 8'h00;
  localparam logic [7:0] ADR_WINDOW     = 8'h01;
  localparam logic [7:0] ADR_REFRESH    = 8'h02;
  localparam logic [7:0] ADR_SCORE      = 8'h03;
  localparam logic [7:0] ADR_EVENT      = 8'h04;
  localparam logic [7:0] ADR_KEEP       = 8'h05;
  localparam logic [7:0] ADR_STATUS     = 8'h06;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_SUP_EN    = 0;
  localparam int CTRL_STBY_EN   = 1;
  localparam int CTRL_EV_HARD   = 2;
  localparam int CTRL_PIN_MASK  = 3;
  localparam int REFR_FLAG      = 0;
  localparam int REFR_PIN       = 1;
  localparam int WIN_LSB        = 0;
  localparam int SCORE_VAL_LSB  = 0;
  localparam int SCORE_LIM_LSB  = 4;
  localparam int EVT_TALLY_LSB  = 0;
  localparam int EVT_LIM_LSB    = 4;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_RUNNING   = 4;
  localparam int STAT_FAILSAFE  = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values of the bits that have no one-time default
  localparam logic RST_EV_HARD  = 1'b0;
  localparam logic RST_PIN_MASK = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Scoring
  localparam logic [2:0] MISS_STEP      = 3'h2;
  localparam logic [2:0] MISS_EARLY_LIM = 3'h2;
  localparam logic [2:0] SCORE_MAX      = 3'h7;
  localparam logic [3:0] TALLY_MAX      = 4'hF;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ    = 25;
  localparam int MS_US      = 1000;
  localparam int MS_CYC     = MS_US * CLK_MHZ;
  localparam int SETTLE_US  = 30;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int WAIT_W     = 10;

  typedef enum logic [3:0] {
    ST_INIT      = 4'h0,
    ST_OFF       = 4'h1,
    ST_PWRUP     = 4'h2,
    ST_RUN       = 4'h3,
    ST_STBY      = 4'h4,
    ST_SOFT      = 4'h5,
    ST_SOFT_WAIT = 4'h6,
    ST_HARD      = 4'h7,
    ST_HARD_WAIT = 4'h8,
    ST_FAIL      = 4'h9
  } pws_state_e;

endpackage

// ===== core/pws_core.sv
`timescale 1ns/1ps
module pws_core #(
  parameter int NREG       = 11,
  parameter int CYC_PER_MS = pws_pkg::MS_CYC
) (
  input  wire logic                      CLOCK_I,
  input  wire logic                      RST_N_I,
  input  wire logic [pws_pkg::ADDR_W-1:0] ADDR_I,
  input  wire logic [pws_pkg::DATA_W-1:0] WDATA_I,
  input  wire logic                      WR_I,
  input  wire logic                      RD_I,
  input  wire logic                      SECURE_WR_I,
  input  wire logic                      PROTECT_EN_I,
  input  wire logic [3:0]                DEFAULT_WINDOW_LENGTH_I,
  input  wire logic [2:0]                DEFAULT_MISS_LIMIT_I,
  input  wire logic [3:0]                DEFAULT_EVENT_LIMIT_I,
  input  wire logic                      DEFAULT_SUPERVISOR_ENABLE_I,
  input  wire logic                      DEFAULT_STANDBY_SUPERVISE_I,
  input  wire logic                      WINDOWED_SELECT_I,
  input  wire logic                      POWER_UP_REQ_I,
  input  wire logic                      OFF_REQ_I,
  input  wire logic                      PWRUP_DONE_I,
  input  wire logic                      STANDBY_REQ_I,
  input  wire logic                      HOST_SUPERVISE_IN_I,
  input  wire logic                      REG_SETTLED_I,
  input  wire logic                      PDN_DONE_I,
  input  wire logic                      FAIL_SYNC_N_I,
  input  wire logic [NREG-1:0]           REG_SEQUENCED_I,
  input  wire logic                      PG_IN_SEQ_I,
  output logic      [pws_pkg::DATA_W-1:0] RDATA_O,
  output logic                           HOST_RESET_OUT_N_O,
  output logic                           POWER_GOOD_OUT_O,
  output logic                           POWER_DOWN_O,
  output logic                           SOFT_RELOAD_O,
  output logic                           FULL_RELOAD_O,
  output logic      [NREG-1:0]           REG_RESTORE_O,
  output logic      [NREG-1:0]           REG_SHUTOFF_O,
  output logic                           WD_EVENT_O,
  output logic                           FAILSAFE_O,
  output logic                           IRQ_OUT_N_O
);

  localparam int DIV_W = $clog2(CYC_PER_MS + 1);

  typedef struct packed {
    pws_pkg::pws_state_e        state;
    logic [DIV_W-1:0]           div;
    logic [15:0]                ms_cnt;
    logic                       running;
    logic                       refresh_pending_flag;
    logic [2:0]                 miss_score;
    logic [2:0]                 miss_limit;
    logic [3:0]                 event_tally;
    logic [3:0]                 event_limit;
    logic                       supervisor_enable;
    logic                       standby_supervise_enable;
    logic                       pin_event_reset_type;
    logic                       pin_event_mask;
    logic                       pin_event_flag;
    logic [3:0]                 window_length_code;
    logic [NREG-1:0]            keep_config_on_soft_reset;
    logic [pws_pkg::WAIT_W-1:0] wait_cnt;
    logic                       sup_prev;
    logic [pws_pkg::DATA_W-1:0] rdata;
    logic                       host_rst_n;
    logic                       pg;
    logic                       pdn;
    logic                       soft_reload;
    logic                       full_reload;
    logic [NREG-1:0]            restore;
    logic [NREG-1:0]            shutoff;
    logic                       wd_event;
    logic                       failsafe;
    logic                       irq_n;
  } pws_st_s;

  pws_st_s    r;
  pws_st_s    n;
  logic       sys_on;
  logic       run_ok;
  logic       ms_tick;
  logic       early;
  logic       expire;
  logic       clr_req;
  logic       ok_ref;
  logic       miss;
  logic       tmr_event;
  logic       pin_event;
  logic       ev_hard;
  logic       do_soft;
  logic       do_full;
  logic [2:0] score_up;
  logic [3:0] tally_up;

  function automatic logic [15:0] win_period(input logic [3:0] code);
    win_period = 16'h0001 << code;
  endfunction

  function automatic logic is_on(input pws_pkg::pws_state_e s);
    is_on = (s == pws_pkg::ST_RUN) || (s == pws_pkg::ST_STBY) ||
            (s == pws_pkg::ST_SOFT) || (s == pws_pkg::ST_SOFT_WAIT);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n         = r;
    ms_tick   = 1'b0;
    early     = 1'b0;
    expire    = 1'b0;
    ok_ref    = 1'b0;
    miss      = 1'b0;
    tmr_event = 1'b0;
    do_soft   = 1'b0;
    do_full   = 1'b0;
    score_up  = r.miss_score;
    tally_up  = r.event_tally;
    sys_on    = is_on(r.state);
    run_ok    = r.supervisor_enable && ((r.state == pws_pkg::ST_RUN) ||
                ((r.state == pws_pkg::ST_STBY) && r.standby_supervise_enable));
    clr_req   = WR_I && sys_on && (ADDR_I == pws_pkg::ADR_REFRESH) &&
                WDATA_I[pws_pkg::REFR_FLAG] && r.refresh_pending_flag && r.running;
    pin_event = ((r.state == pws_pkg::ST_RUN) || (r.state == pws_pkg::ST_STBY)) &&
                r.sup_prev && !HOST_SUPERVISE_IN_I;
    n.sup_prev    = HOST_SUPERVISE_IN_I;
    n.rdata       = '0;
    n.soft_reload = 1'b0;
    n.full_reload = 1'b0;
    n.restore     = '0;
    n.shutoff     = '0;
    n.wd_event    = 1'b0;

    // Window timer
    if (!run_ok) begin
      n.div     = '0;
      n.ms_cnt  = '0;
      n.running = 1'b0;
    end else if (!r.running) begin
      n.running              = 1'b1;
      n.refresh_pending_flag = 1'b1;
    end else begin
      ms_tick = (r.div == DIV_W'(CYC_PER_MS - 1));
      n.div   = ms_tick ? '0 : DIV_W'(r.div + 1'b1);
      if (ms_tick) begin
        n.ms_cnt = 16'(r.ms_cnt + 16'h0001);
      end
      early  = WINDOWED_SELECT_I && (r.ms_cnt < (win_period(r.window_length_code) >> 1));
      expire = ms_tick && (16'(r.ms_cnt + 16'h0001) == win_period(r.window_length_code));
      ok_ref = clr_req && !early;
      miss   = (clr_req && early) || (expire && !ok_ref);
      if (ok_ref || miss) begin
        n.ms_cnt               = '0;
        n.div                  = '0;
        n.refresh_pending_flag = 1'b1;
      end
      if (ok_ref && (r.miss_score != 3'h0)) begin
        n.miss_score = r.miss_score - 3'h1;
      end
      if (miss) begin
        score_up     = (r.miss_score > (pws_pkg::SCORE_MAX - pws_pkg::MISS_STEP)) ?
                       pws_pkg::SCORE_MAX : 3'(r.miss_score + pws_pkg::MISS_STEP);
        n.miss_score = score_up;
        tmr_event    = (score_up == r.miss_limit) ||
                       (r.miss_limit <= pws_pkg::MISS_EARLY_LIM);
      end
    end

    // Register writes
    if (WR_I && sys_on) begin
      case (ADDR_I)
        pws_pkg::ADR_CTRL: begin
          if (!PROTECT_EN_I || SECURE_WR_I) begin
            n.supervisor_enable        = WDATA_I[pws_pkg::CTRL_SUP_EN];
            n.standby_supervise_enable = WDATA_I[pws_pkg::CTRL_STBY_EN];
          end
          n.pin_event_reset_type = WDATA_I[pws_pkg::CTRL_EV_HARD];
          n.pin_event_mask       = WDATA_I[pws_pkg::CTRL_PIN_MASK];
        end
        pws_pkg::ADR_WINDOW: begin
          n.window_length_code = WDATA_I[pws_pkg::WIN_LSB +: 4];
          if (WDATA_I[pws_pkg::WIN_LSB +: 4] != r.window_length_code) begin
            n.ms_cnt = '0;
            n.div    = '0;
          end
        end
        pws_pkg::ADR_REFRESH: begin
          if (WDATA_I[pws_pkg::REFR_PIN]) begin
            n.pin_event_flag = 1'b0;
          end
        end
        pws_pkg::ADR_SCORE: n.miss_limit = WDATA_I[pws_pkg::SCORE_LIM_LSB +: 3];
        pws_pkg::ADR_EVENT: begin
          n.event_tally = WDATA_I[pws_pkg::EVT_TALLY_LSB +: 4];
          n.event_limit = WDATA_I[pws_pkg::EVT_LIM_LSB +: 4];
        end
        pws_pkg::ADR_KEEP: n.keep_config_on_soft_reset = WDATA_I[NREG-1:0];
        default: ;
      endcase
    end

    // Register reads
    if (RD_I) begin
      case (ADDR_I)
        pws_pkg::ADR_CTRL: begin
          n.rdata[pws_pkg::CTRL_SUP_EN]   = r.supervisor_enable;
          n.rdata[pws_pkg::CTRL_STBY_EN]  = r.standby_supervise_enable;
          n.rdata[pws_pkg::CTRL_EV_HARD]  = r.pin_event_reset_type;
          n.rdata[pws_pkg::CTRL_PIN_MASK] = r.pin_event_mask;
        end
        pws_pkg::ADR_WINDOW: n.rdata[pws_pkg::WIN_LSB +: 4] = r.window_length_code;
        pws_pkg::ADR_REFRESH: begin
          n.rdata[pws_pkg::REFR_FLAG] = r.refresh_pending_flag;
          n.rdata[pws_pkg::REFR_PIN]  = r.pin_event_flag;
        end
        pws_pkg::ADR_SCORE: begin
          n.rdata[pws_pkg::SCORE_VAL_LSB +: 3] = r.miss_score;
          n.rdata[pws_pkg::SCORE_LIM_LSB +: 3] = r.miss_limit;
        end
        pws_pkg::ADR_EVENT: begin
          n.rdata[pws_pkg::EVT_TALLY_LSB +: 4] = r.event_tally;
          n.rdata[pws_pkg::EVT_LIM_LSB +: 4]   = r.event_limit;
        end
        pws_pkg::ADR_KEEP: n.rdata[NREG-1:0] = r.keep_config_on_soft_reset;
        pws_pkg::ADR_STATUS: begin
          n.rdata[pws_pkg::STAT_STATE_LSB +: 4] = r.state;
          n.rdata[pws_pkg::STAT_RUNNING]        = r.running;
          n.rdata[pws_pkg::STAT_FAILSAFE]       = r.failsafe;
        end
        default: ;
      endcase
    end

    // Supervisor sequence
    ev_hard = tmr_event || r.pin_event_reset_type;
    unique case (r.state)
      pws_pkg::ST_INIT: begin
        do_full = 1'b1;
        n.state = pws_pkg::ST_OFF;
      end
      pws_pkg::ST_OFF: begin
        if (POWER_UP_REQ_I) begin
          do_full = 1'b1;
          n.state = pws_pkg::ST_PWRUP;
        end
      end
      pws_pkg::ST_PWRUP: begin
        if (PWRUP_DONE_I && FAIL_SYNC_N_I) begin
          n.state = STANDBY_REQ_I ? pws_pkg::ST_STBY : pws_pkg::ST_RUN;
        end
      end
      pws_pkg::ST_RUN, pws_pkg::ST_STBY: begin
        n.state = STANDBY_REQ_I ? pws_pkg::ST_STBY : pws_pkg::ST_RUN;
        if (tmr_event || pin_event) begin
          n.wd_event    = 1'b1;
          n.miss_score  = 3'h0;
          tally_up      = (r.event_tally == pws_pkg::TALLY_MAX) ? r.event_tally : 4'(r.event_tally + 4'h1);
          n.event_tally = tally_up;
          if (tally_up == r.event_limit) begin
            n.state = pws_pkg::ST_FAIL;
          end else if (ev_hard) begin
            n.state = pws_pkg::ST_HARD;
          end else begin
            n.state       = pws_pkg::ST_SOFT;
            do_soft       = 1'b1;
            n.soft_reload = 1'b1;
            n.restore     = REG_SEQUENCED_I & ~r.keep_config_on_soft_reset;
            n.shutoff     = ~REG_SEQUENCED_I & ~r.keep_config_on_soft_reset;
          end
        end
      end
      pws_pkg::ST_SOFT: begin
        if (REG_SETTLED_I) begin
          n.state    = pws_pkg::ST_SOFT_WAIT;
          n.wait_cnt = '0;
        end
      end
      pws_pkg::ST_SOFT_WAIT: begin
        n.wait_cnt = pws_pkg::WAIT_W'(r.wait_cnt + 1'b1);
        if (r.wait_cnt == pws_pkg::WAIT_W'(pws_pkg::SETTLE_CYC - 1)) begin
          n.state          = STANDBY_REQ_I ? pws_pkg::ST_STBY : pws_pkg::ST_RUN;
          n.pin_event_flag = 1'b1;
        end
      end
      pws_pkg::ST_HARD: begin
        if (PDN_DONE_I) begin
          n.state    = pws_pkg::ST_HARD_WAIT;
          n.wait_cnt = '0;
        end
      end
      pws_pkg::ST_HARD_WAIT: begin
        n.wait_cnt = pws_pkg::WAIT_W'(r.wait_cnt + 1'b1);
        if (r.wait_cnt == pws_pkg::WAIT_W'(pws_pkg::SETTLE_CYC - 1)) begin
          do_full = 1'b1;
          n.state = pws_pkg::ST_PWRUP;
        end
      end
      pws_pkg::ST_FAIL: ;
      default: n.state = pws_pkg::ST_OFF;
    endcase

    if (OFF_REQ_I && (r.state != pws_pkg::ST_INIT)) begin
      n.state       = pws_pkg::ST_OFF;
      n.event_tally = 4'h0;
      n.miss_score  = 3'h0;
    end

    // Default reloads: soft is the partial set, full adds the rest
    if (do_soft || do_full) begin
      n.supervisor_enable         = DEFAULT_SUPERVISOR_ENABLE_I;
      n.standby_supervise_enable  = DEFAULT_STANDBY_SUPERVISE_I;
      n.window_length_code        = DEFAULT_WINDOW_LENGTH_I;
      n.keep_config_on_soft_reset = '0;
      n.ms_cnt                    = '0;
      n.div                       = '0;
    end
    if (do_full) begin
      n.full_reload          = 1'b1;
      n.miss_limit           = DEFAULT_MISS_LIMIT_I;
      n.event_limit          = DEFAULT_EVENT_LIMIT_I;
      n.pin_event_reset_type = pws_pkg::RST_EV_HARD;
      n.pin_event_mask       = pws_pkg::RST_PIN_MASK;
      n.pin_event_flag       = 1'b0;
      n.miss_score           = 3'h0;
    end

    // Outputs, registered from the next state
    n.host_rst_n = is_on(n.state);
    n.pdn        = (n.state == pws_pkg::ST_HARD) || (n.state == pws_pkg::ST_HARD_WAIT) ||
                   (n.state == pws_pkg::ST_FAIL) || (n.state == pws_pkg::ST_OFF);
    n.pg         = is_on(n.state) ? 1'b1 : (PG_IN_SEQ_I ? 1'b0 : r.pg);
    n.failsafe   = (n.state == pws_pkg::ST_FAIL);
    n.irq_n      = !(n.pin_event_flag && !n.pin_event_mask);
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      r       <= '0;
      r.irq_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign RDATA_O            = r.rdata;
  assign HOST_RESET_OUT_N_O = r.host_rst_n;
  assign POWER_GOOD_OUT_O   = r.pg;
  assign POWER_DOWN_O       = r.pdn;
  assign SOFT_RELOAD_O      = r.soft_reload;
  assign FULL_RELOAD_O      = r.full_reload;
  assign REG_RESTORE_O      = r.restore;
  assign REG_SHUTOFF_O      = r.shutoff;
  assign WD_EVENT_O         = r.wd_event;
  assign FAILSAFE_O         = r.failsafe;
  assign IRQ_OUT_N_O        = r.irq_n;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);

  a_flag_on_start: assert property ($rose(r.running) |-> r.refresh_pending_flag)
    else $error("timer started without pending flag");
  a_refresh_restart: assert property (ok_ref && !pin_event && !(WR_I && ADDR_I == pws_pkg::ADR_WINDOW)
    |=> r.ms_cnt == 16'h0000 && r.refresh_pending_flag && !WD_EVENT_O)
    else $error("good refresh did not restart timer");
  a_off_idle: assert property (r.state == pws_pkg::ST_OFF |=> !r.running && r.ms_cnt == 16'h0000)
    else $error("timer active in off state");
  a_never_past_window: assert property (r.running |-> r.ms_cnt < win_period(r.window_length_code))
    else $error("timer passed window length");
  a_code_change: assert property (WR_I && sys_on && ADDR_I == pws_pkg::ADR_WINDOW &&
    WDATA_I[3:0] != r.window_length_code |=> r.ms_cnt == 16'h0000)
    else $error("window change did not restart timer");
  a_score_down: assert property (ok_ref && r.miss_score != 3'h0 && !pin_event
    && !OFF_REQ_I |=> r.miss_score == $past(r.miss_score) - 3'h1)
    else $error("miss score not lowered by one");
  a_score_up: assert property (miss && !tmr_event && !pin_event && !OFF_REQ_I |=>
    r.miss_score == (($past(r.miss_score) > 3'h5) ? 3'h7 : $past(r.miss_score) + 3'h2))
    else $error("miss score not raised by two");
  a_limit_event: assert property (miss && score_up == r.miss_limit && !OFF_REQ_I &&
    (r.state == pws_pkg::ST_RUN || r.state == pws_pkg::ST_STBY) |=> WD_EVENT_O)
    else $error("score at limit without event");
  a_low_limit: assert property (expire && !ok_ref && r.miss_limit <= 3'h2 && !OFF_REQ_I |=> WD_EVENT_O)
    else $error("low limit did not trigger on expiry");
  a_early_clear: assert property (clr_req && early |-> miss && !ok_ref)
    else $error("first-half clear taken as refresh");
  a_soft_host_rst: assert property (r.state inside {pws_pkg::ST_SOFT, pws_pkg::ST_SOFT_WAIT}
    |-> HOST_RESET_OUT_N_O && POWER_GOOD_OUT_O)
    else $error("host reset asserted during soft reset");
  a_settle_time: assert property (r.state == pws_pkg::ST_SOFT_WAIT && !OFF_REQ_I &&
    n.state != pws_pkg::ST_SOFT_WAIT |-> r.wait_cnt == pws_pkg::WAIT_W'(pws_pkg::SETTLE_CYC - 1))
    else $error("soft reset left before settle time");
  a_hard_power_down: assert property (r.state == pws_pkg::ST_HARD |-> POWER_DOWN_O && !HOST_RESET_OUT_N_O)
    else $error("hard reset without power down");
  a_timer_hard: assert property (tmr_event && !OFF_REQ_I && (r.state == pws_pkg::ST_RUN ||
    r.state == pws_pkg::ST_STBY) |=> r.state inside {pws_pkg::ST_HARD, pws_pkg::ST_FAIL})
    else $error("timer event did not hard reset");
  a_tally_off: assert property (r.state == pws_pkg::ST_OFF |-> r.event_tally == 4'h0)
    else $error("event tally kept in off state");

endmodule

// ===== dv/pws_host.sv
`timescale 1ns/1ps
// Host side of the register port; each access starts just after a rising edge
module pws_host (
  input  wire logic        clk_i,
  input  wire logic [15:0] rdata_i,
  output logic      [7:0]  addr_o,
  output logic      [15:0] wdata_o,
  output logic             wr_o,
  output logic             rd_o
);
  initial begin
    addr_o = 8'h00;
    wdata_o = 16'h0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    @(negedge clk_i);
    d = rdata_i;
    @(posedge clk_i);
  endtask
endmodule

// ===== dv/pws_core_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t got %0h exp %0h", $time, a, e); end end
module pws_core_tb;
  logic        CLOCK_I, RST_N_I, WR_I, RD_I, POWER_UP_REQ_I, OFF_REQ_I, HOST_SUPERVISE_IN_I;
  logic [7:0]  ADDR_I;
  logic [15:0] WDATA_I, RDATA_O, d;
  logic [10:0] REG_RESTORE_O, REG_SHUTOFF_O;
  logic        HOST_RESET_OUT_N_O, POWER_GOOD_OUT_O, POWER_DOWN_O, SOFT_RELOAD_O, FULL_RELOAD_O;
  logic        WD_EVENT_O, FAILSAFE_O, IRQ_OUT_N_O;
  logic        SECURE_WR_I, PROTECT_EN_I, DEFAULT_STANDBY_SUPERVISE_I, WINDOWED_SELECT_I, STANDBY_REQ_I;
  logic        PWRUP_DONE_I, REG_SETTLED_I, PDN_DONE_I, FAIL_SYNC_N_I, PG_IN_SEQ_I;
  int          n_mismatch = 0, samples_checked = 0, cyc = 0;
  pws_core #(.CYC_PER_MS(4)) dut (.*, .DEFAULT_WINDOW_LENGTH_I(4'h8), .DEFAULT_MISS_LIMIT_I(3'h5),
    .DEFAULT_EVENT_LIMIT_I(4'h3), .DEFAULT_SUPERVISOR_ENABLE_I(1'b1), .REG_SEQUENCED_I(11'h0F0));
  pws_host host (.clk_i(CLOCK_I), .rdata_i(RDATA_O), .addr_o(ADDR_I), .wdata_o(WDATA_I), .wr_o(WR_I), .rd_o(RD_I));
  initial begin
    CLOCK_I = 1'b0;
    forever #20 CLOCK_I = ~CLOCK_I;
  end
  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge CLOCK_I) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    host.rd(a, d);
    `CHK(d, e)
  endtask
  initial begin
    RST_N_I = 1'b0;
    POWER_UP_REQ_I = 1'b0;
    OFF_REQ_I = 1'b0;
    HOST_SUPERVISE_IN_I = 1'b1;
    {SECURE_WR_I, PROTECT_EN_I, DEFAULT_STANDBY_SUPERVISE_I, WINDOWED_SELECT_I, STANDBY_REQ_I} = 5'h00;
    {PWRUP_DONE_I, REG_SETTLED_I, PDN_DONE_I, FAIL_SYNC_N_I, PG_IN_SEQ_I} = 5'h13;
    repeat (3) @(posedge CLOCK_I);
    RST_N_I <= 1'b1;
    repeat (3) @(posedge CLOCK_I);
    rd(8'h06, 16'h0001);
    POWER_UP_REQ_I <= 1'b1;
    repeat (4) @(posedge CLOCK_I);
    rd(8'h06, 16'h0013);
    rd(8'h02, 16'h0001);
    rd(8'h01, 16'h0008);
    host.wr(8'h01, 16'h0002);
    repeat (20) @(posedge CLOCK_I);
    rd(8'h03, 16'h0052);
    host.wr(8'h02, 16'h0001);
    rd(8'h03, 16'h0051);
    $display("test scoring done");
    for (int i = 0; i < 60 && WD_EVENT_O !== 1'b1; i++) @(negedge CLOCK_I);
    `CHK(WD_EVENT_O, 1'b1)
    repeat (3) @(posedge CLOCK_I);
    `CHK({POWER_DOWN_O, HOST_RESET_OUT_N_O, POWER_GOOD_OUT_O}, 3'b100)
    rd(8'h06, 16'h0007);
    PDN_DONE_I <= 1'b1;
    FAIL_SYNC_N_I <= 1'b0;
    rd(8'h04, 16'h0031);
    for (int i = 0; i < 900 && FULL_RELOAD_O !== 1'b1; i++) @(negedge CLOCK_I);
    `CHK(FULL_RELOAD_O, 1'b1)
    @(posedge CLOCK_I);
    rd(8'h06, 16'h0002);
    FAIL_SYNC_N_I <= 1'b1;
    for (int i = 0; i < 900 && HOST_RESET_OUT_N_O !== 1'b1; i++) @(posedge CLOCK_I);
    repeat (2) @(posedge CLOCK_I);
    rd(8'h01, 16'h0008);
    $display("test hard reset done");
    host.wr(8'h05, 16'h0030);
    host.wr(8'h00, 16'h0001);
    HOST_SUPERVISE_IN_I <= 1'b0;
    for (int i = 0; i < 20 && SOFT_RELOAD_O !== 1'b1; i++) @(negedge CLOCK_I);
    `CHK({REG_RESTORE_O, REG_SHUTOFF_O}, {11'h0C0, 11'h70F})
    `CHK({HOST_RESET_OUT_N_O, POWER_GOOD_OUT_O}, 2'b11)
    @(posedge CLOCK_I);
    HOST_SUPERVISE_IN_I <= 1'b1;
    REG_SETTLED_I <= 1'b1;
    for (int i = 0; i < 900 && IRQ_OUT_N_O !== 1'b0; i++) @(posedge CLOCK_I);
    @(posedge CLOCK_I);
    `CHK(IRQ_OUT_N_O, 1'b0)
    rd(8'h06, 16'h0013);
    rd(8'h02, 16'h0003);
    host.wr(8'h02, 16'h0002);
    `CHK(IRQ_OUT_N_O, 1'b1)
    $display("test soft reset done");
    PROTECT_EN_I <= 1'b1;
    host.wr(8'h00, 16'h0008);
    rd(8'h00, 16'h0009);
    SECURE_WR_I <= 1'b1;
    host.wr(8'h00, 16'h0002);
    SECURE_WR_I <= 1'b0;
    rd(8'h06, 16'h0003);
    STANDBY_REQ_I <= 1'b1;
    SECURE_WR_I <= 1'b1;
    host.wr(8'h00, 16'h0003);
    SECURE_WR_I <= 1'b0;
    rd(8'h06, 16'h0014);
    SECURE_WR_I <= 1'b1;
    host.wr(8'h00, 16'h0001);
    SECURE_WR_I <= 1'b0;
    rd(8'h06, 16'h0004);
    STANDBY_REQ_I <= 1'b0;
    WINDOWED_SELECT_I <= 1'b1;
    repeat (2) @(posedge CLOCK_I);
    host.wr(8'h02, 16'h0001);
    rd(8'h03, 16'h0052);
    WINDOWED_SELECT_I <= 1'b0;
    $display("test enables done");
    HOST_SUPERVISE_IN_I <= 1'b0;
    repeat (5) @(posedge CLOCK_I);
    `CHK(FAILSAFE_O, 1'b1)
    POWER_UP_REQ_I <= 1'b0;
    OFF_REQ_I <= 1'b1;
    repeat (3) @(posedge CLOCK_I);
    rd(8'h04, 16'h0030);
    rd(8'h06, 16'h0001);
    $display("test fail-safe done");
    finish_test();
  end
endmodule
